// file: bench/eirs_host.sv
// Host controller model that sets up the input route selector over AXI4-Lite.
// Assumes one aclk shared with the slave; tasks are called from the bench top.
`include "eirs_regs.svh"

module eirs_host (
  input wire logic aclk,
  output logic [`EIRS_ADDR_W-1:0] s_axi_awaddr,
  output logic [2:0] s_axi_awprot,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [`EIRS_ADDR_W-1:0] s_axi_araddr,
  output logic [2:0] s_axi_arprot,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    s_axi_awaddr = '0;
    s_axi_awprot = 3'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = '0;
    s_axi_arprot = 3'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
    input logic [3:0] s = 4'hf);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    // Each answer is left waiting one cycle, so the slave must hold it steady.
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!(s_axi_arvalid && s_axi_arready));
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // Amplifiers are shut down before their channels switch to supply measurement.
  task automatic supply_set(input logic [2:0] en);
    logic [1:0] r;
    wr(`EIRS_OFF_SHDN, {29'h0, en}, r);
    wr(`EIRS_OFF_SUPPLY, {29'h0, en}, r);
  endtask : supply_set
endmodule : eirs_host

// file: bench/tb.sv
// Self-checking bench for the input route selector top.
// Assumes eirs_pkg and the register header are compiled first.
`include "eirs_regs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import eirs_pkg::*;

  typedef struct packed {
    logic sup;
    logic [7:0] ctl;
    eirs_route_s exp;
  } eirs_tb_row_s;

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [`EIRS_ADDR_W-1:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  eirs_route_s [`EIRS_CHAN_COUNT-1:0] chan_route;
  eirs_route_s pace_route;
  logic [`EIRS_CHAN_COUNT-1:0] amplifier_shutdown;
  logic sample_ready_n;
  integer errors = 0;
  integer num_checks = 0;
  integer cyc = 0;
  integer n;

  eirs_tb_row_s rows [9] = '{
    '{1'b0, 8'h11, '{EIRS_MODE_PIN, 1'b0, 1'b0, 6'h01, 6'h02}},
    '{1'b0, 8'h2e, '{EIRS_MODE_PIN, 1'b0, 1'b0, 6'h20, 6'h10}},
    '{1'b0, 8'h38, '{EIRS_MODE_PIN, 1'b0, 1'b0, 6'h00, 6'h00}},
    '{1'b0, 8'hd1, '{EIRS_MODE_SHORT, 1'b0, 1'b0, 6'h00, 6'h00}},
    '{1'b0, 8'h51, '{EIRS_MODE_TEST_POS, 1'b0, 1'b0, 6'h00, 6'h00}},
    '{1'b0, 8'h91, '{EIRS_MODE_TEST_NEG, 1'b0, 1'b0, 6'h00, 6'h00}},
    '{1'b1, 8'hd1, '{EIRS_MODE_SUPPLY, 1'b1, 1'b1, 6'h00, 6'h00}},
    '{1'b1, 8'h23, '{EIRS_MODE_SUPPLY, 1'b1, 1'b1, 6'h00, 6'h00}},
    '{1'b0, 8'h1c, '{EIRS_MODE_PIN, 1'b0, 1'b0, 6'h08, 6'h04}}
  };

  initial begin
    forever #4 aclk = ~aclk;
  end

  eirs_top u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(awprot), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(arprot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .chan_route(chan_route), .pace_route(pace_route),
    .amplifier_shutdown(amplifier_shutdown), .sample_ready_n(sample_ready_n)
  );

  eirs_host u_host (
    .aclk(aclk),
    .s_axi_awaddr(awaddr), .s_axi_awprot(awprot), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(arprot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  task automatic stop_test;
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk_route(input eirs_route_s got, input eirs_route_s exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: route %h, expected %h", $time, got, exp);
    end
  endtask : chk_route

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk_val

  // Ends a hung run well past the expected length of all tests.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      stop_test;
    end
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_route(chan_route[0], '0);
    chk_val({29'h0, amplifier_shutdown}, 32'h0);
    chk_val({31'h0, sample_ready_n}, 32'h1);
    u_host.rd(`EIRS_OFF_PERIOD, d, r);
    chk_val(d, 32'h180);
    for (int i = 0; i < 9; i++) begin
      for (int ch = 0; ch < 3; ch++) begin
        u_host.wr(8'(4 * ch), {24'h0, rows[i].ctl}, r);
      end
      u_host.supply_set({3{rows[i].sup}});
      repeat (2) @(posedge aclk);
      for (int ch = 0; ch < 3; ch++) begin
        chk_route(chan_route[ch], rows[i].exp);
      end
      chk_val({29'h0, amplifier_shutdown}, {29'h0, {3{rows[i].sup}}});
      u_host.rd(`EIRS_OFF_ROUTE1, d, r);
      chk_val(d, {24'h0, rows[i].ctl});
      u_host.rd(`EIRS_OFF_STATUS, d, r);
      chk_val({23'h0, d[8:0]}, {23'h0, rows[i].exp.mode, rows[i].exp.mode, rows[i].exp.mode});
    end
    // Pace channel keeps pin routing even with its unused test bits set.
    u_host.wr(`EIRS_OFF_PACE, 32'hce, r);
    repeat (2) @(posedge aclk);
    chk_route(pace_route, '{EIRS_MODE_PIN, 1'b0, 1'b0, 6'h20, 6'h01});
    u_host.wr(8'h20, 32'hff, r);
    chk_val({30'h0, r}, 32'h2);
    u_host.rd(8'h20, d, r);
    chk_val({r, d[29:0]}, 32'h80000000);
    u_host.wr(`EIRS_OFF_STATUS, 32'h0, r);
    chk_val({30'h0, r}, 32'h0);
    u_host.rd(`EIRS_OFF_STATUS, d, r);
    chk_val({23'h0, d[8:0]}, 32'h0);
    // A period below the minimum acts as the minimum of eight oscillator periods.
    u_host.wr(`EIRS_OFF_PERIOD, 32'h3, r);
    n = 0;
    while (sample_ready_n !== 1'b0 && n < 6000) begin
      @(posedge aclk);
      n++;
    end
    n = 0;
    while (sample_ready_n === 1'b0 && n < 5000) begin
      @(posedge aclk);
      n++;
    end
    chk_val(n, 1220);
    while (sample_ready_n === 1'b1 && n < 5000) begin
      @(posedge aclk);
      n++;
    end
    chk_val(n, 2440);
    // Only the upper byte lane is enabled, so the low period byte must survive.
    u_host.wr(`EIRS_OFF_PERIOD, 32'h3355, r, 4'h2);
    u_host.rd(`EIRS_OFF_PERIOD, d, r);
    chk_val(d, 32'h3303);
    // A reset while the ready pin is low, during a pulse, returns channel 0's route, the period and the ready pin to idle.
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_route(chan_route[0], '0);
    chk_val({31'h0, sample_ready_n}, 32'h1);
    u_host.rd(`EIRS_OFF_PERIOD, d, r);
    chk_val(d, 32'h180);
    stop_test;
  end
endmodule : tb

// file: core/eirs_pkg.sv
// Types shared by the input route selector modules.
// Assumes eirs_regs.svh supplies the field widths.
`include "eirs_regs.svh"

package eirs_pkg;

  typedef enum logic [2:0] {
    EIRS_MODE_PIN,
    EIRS_MODE_SHORT,
    EIRS_MODE_TEST_POS,
    EIRS_MODE_TEST_NEG,
    EIRS_MODE_SUPPLY
  } eirs_mode_e;

  // Software view of one route control byte: pin codes 1 to 6 name a pin, others leave it open.
  typedef struct packed {
    logic [1:0] test_sel;
    logic [2:0] neg_sel;
    logic [2:0] pos_sel;
  } eirs_route_ctl_s;

  // Resolved switch settings of one channel.
  typedef struct packed {
    eirs_mode_e mode;
    logic pos_from_supply;
    logic neg_from_ref;
    logic [`EIRS_PIN_COUNT-1:0] pos_pin;
    logic [`EIRS_PIN_COUNT-1:0] neg_pin;
  } eirs_route_s;

endpackage : eirs_pkg

// file: core/eirs_regs.svh
// Register offsets, field positions, reset values and timing counts of the input route selector.
// Assumes an AXI4-Lite slave with 32-bit data, byte addresses and a 125 MHz aclk.
// Functional notes
// - Supply-monitor enable set: channel measures supply, pin and test fields ignored.
// - Monitor off and test field nonzero: test connection applied, pin fields ignored.
// - Test field 11 shorts both differential inputs, giving zero signal.
// - Test field 01 connects the internal DC test reference, positive polarity.
// - Test field 10 connects the same test reference, negative polarity.
// - Test field 00 routes inputs to the pins named by both selection fields.
// - Three channels and pace channel pick any of six pins, changeable live.
// - Supply mode: supply to modulator positive input, reference to negative input.
// - Active-low sample ready pulses once per output period, four oscillator periods.
// - All three channels stay sample-synchronized whatever their filter settings.
`ifndef EIRS_REGS_SVH
`define EIRS_REGS_SVH

`define EIRS_ADDR_W 8
`define EIRS_OFF_ROUTE0 8'h00
`define EIRS_OFF_ROUTE1 8'h04
`define EIRS_OFF_ROUTE2 8'h08
`define EIRS_OFF_PACE 8'h0c
`define EIRS_OFF_SUPPLY 8'h10
`define EIRS_OFF_SHDN 8'h14
`define EIRS_OFF_PERIOD 8'h18
`define EIRS_OFF_STATUS 8'h1c

`define EIRS_ROUTE_W 8
`define EIRS_TEST_SHORT 2'h3
`define EIRS_TEST_POS 2'h1
`define EIRS_TEST_NEG 2'h2
`define EIRS_TEST_OFF 2'h0
`define EIRS_PIN_COUNT 6
`define EIRS_CHAN_COUNT 3

`define EIRS_STAT_READY_BIT 9
`define EIRS_STAT_CNT_LSB 16

`define EIRS_PERIOD_W 16
`define EIRS_PERIOD_RST 16'h0180
`define EIRS_PERIOD_MIN 16'h0008

`define EIRS_CLK_MHZ 125
`define EIRS_OSC_PERIOD_PS 2441406
`define EIRS_OSC_CYC ((`EIRS_OSC_PERIOD_PS * `EIRS_CLK_MHZ) / 1000000)
`define EIRS_READY_OSC 4
`define EIRS_READY_CYC (`EIRS_READY_OSC * `EIRS_OSC_CYC)

`define EIRS_RESP_OKAY 2'h0
`define EIRS_RESP_SLVERR 2'h2

`endif

// file: core/eirs_route_dec.sv
// Priority decoder from one channel's control fields to its switch settings.
// Assumes registered inputs; the result is purely combinational.
`include "eirs_regs.svh"

module eirs_route_dec (
  input wire logic supply_en,
  input eirs_pkg::eirs_route_ctl_s ctl,
  output eirs_pkg::eirs_route_s route
);
  import eirs_pkg::*;

  function automatic logic [`EIRS_PIN_COUNT-1:0] pin_onehot(input logic [2:0] code);
    logic [`EIRS_PIN_COUNT-1:0] hot;
    hot = '0;
    if (code >= 3'h1 && code <= 3'h6) begin
      hot[code - 3'h1] = 1'b1;
    end
    return hot;
  endfunction : pin_onehot

  always_comb begin
    route = '0;
    route.mode = EIRS_MODE_PIN;
    if (supply_en) begin
      route.mode = EIRS_MODE_SUPPLY;
      route.pos_from_supply = 1'b1;
      route.neg_from_ref = 1'b1;
    end else if (ctl.test_sel != `EIRS_TEST_OFF) begin
      unique case (ctl.test_sel)
        `EIRS_TEST_SHORT: route.mode = EIRS_MODE_SHORT;
        `EIRS_TEST_POS: route.mode = EIRS_MODE_TEST_POS;
        default: route.mode = EIRS_MODE_TEST_NEG;
      endcase
    end else begin
      route.pos_pin = pin_onehot(ctl.pos_sel);
      route.neg_pin = pin_onehot(ctl.neg_sel);
    end
  end

endmodule : eirs_route_dec

// file: core/eirs_top.sv
// Register file, route resolution and sample-ready timing of the input route selector.
// Assumes an AXI4-Lite master on aclk and a synchronous active-low reset.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`include "eirs_regs.svh"

module eirs_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`EIRS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`EIRS_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output eirs_pkg::eirs_route_s [`EIRS_CHAN_COUNT-1:0] chan_route,
  output eirs_pkg::eirs_route_s pace_route,
  output logic [`EIRS_CHAN_COUNT-1:0] amplifier_shutdown,
  output logic sample_ready_n
);
  import eirs_pkg::*;

  localparam logic [8:0] OSC_CYC = 9'(`EIRS_OSC_CYC);
  localparam logic [10:0] READY_CYC = 11'(`EIRS_READY_CYC);

  eirs_route_ctl_s [`EIRS_CHAN_COUNT-1:0] channel_route_control_r;
  eirs_route_ctl_s pace_route_control_r;
  logic [`EIRS_CHAN_COUNT-1:0] supply_monitor_enable_r;
  logic [`EIRS_CHAN_COUNT-1:0] front_end_shutdown_control_r;
  logic [`EIRS_PERIOD_W-1:0] period_r;

  logic aw_held_r;
  logic w_held_r;
  logic [`EIRS_ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;

  eirs_route_s [`EIRS_CHAN_COUNT-1:0] dec_route;
  eirs_route_s pace_dec;

  logic [8:0] osc_cnt_r;
  logic osc_tick;
  logic [`EIRS_PERIOD_W-1:0] frame_cnt_r;
  logic [`EIRS_PERIOD_W-1:0] period_eff;
  logic frame_start;
  logic [10:0] low_cnt_r;
  logic [15:0] sample_cnt_r;

  // Write address and data channels are taken independently and joined here.
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

  always_comb begin
    unique case ({aw_addr_r[`EIRS_ADDR_W-1:2], 2'h0})
      `EIRS_OFF_ROUTE0, `EIRS_OFF_ROUTE1, `EIRS_OFF_ROUTE2, `EIRS_OFF_PACE,
      `EIRS_OFF_SUPPLY, `EIRS_OFF_SHDN, `EIRS_OFF_PERIOD, `EIRS_OFF_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_awready) begin
        s_axi_awready <= !s_axi_awvalid;
      end else begin
        s_axi_awready <= !aw_held_r && !s_axi_bvalid;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
      if (s_axi_wready) begin
        s_axi_wready <= !s_axi_wvalid;
      end else begin
        s_axi_wready <= !w_held_r && !s_axi_bvalid;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EIRS_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `EIRS_RESP_OKAY : `EIRS_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Route fields may be rewritten at any time; the new path takes effect two edges later.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_route_control_r <= '0;
      pace_route_control_r <= '0;
      supply_monitor_enable_r <= '0;
      front_end_shutdown_control_r <= '0;
      period_r <= `EIRS_PERIOD_RST;
    end else if (wr_fire) begin
      unique case ({aw_addr_r[`EIRS_ADDR_W-1:2], 2'h0})
        `EIRS_OFF_ROUTE0: if (w_strb_r[0]) channel_route_control_r[0] <= w_data_r[7:0];
        `EIRS_OFF_ROUTE1: if (w_strb_r[0]) channel_route_control_r[1] <= w_data_r[7:0];
        `EIRS_OFF_ROUTE2: if (w_strb_r[0]) channel_route_control_r[2] <= w_data_r[7:0];
        `EIRS_OFF_PACE: if (w_strb_r[0]) pace_route_control_r <= w_data_r[7:0];
        `EIRS_OFF_SUPPLY: if (w_strb_r[0]) supply_monitor_enable_r <= w_data_r[2:0];
        `EIRS_OFF_SHDN: if (w_strb_r[0]) front_end_shutdown_control_r <= w_data_r[2:0];
        `EIRS_OFF_PERIOD: begin
          if (w_strb_r[0]) period_r[7:0] <= w_data_r[7:0];
          if (w_strb_r[1]) period_r[15:8] <= w_data_r[15:8];
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[`EIRS_ADDR_W-1:2], 2'h0})
      `EIRS_OFF_ROUTE0: rd_word[7:0] = channel_route_control_r[0];
      `EIRS_OFF_ROUTE1: rd_word[7:0] = channel_route_control_r[1];
      `EIRS_OFF_ROUTE2: rd_word[7:0] = channel_route_control_r[2];
      `EIRS_OFF_PACE: rd_word[7:0] = pace_route_control_r;
      `EIRS_OFF_SUPPLY: rd_word[2:0] = supply_monitor_enable_r;
      `EIRS_OFF_SHDN: rd_word[2:0] = front_end_shutdown_control_r;
      `EIRS_OFF_PERIOD: rd_word[15:0] = period_r;
      `EIRS_OFF_STATUS: begin
        rd_word[2:0] = chan_route[0].mode;
        rd_word[5:3] = chan_route[1].mode;
        rd_word[8:6] = chan_route[2].mode;
        rd_word[`EIRS_STAT_READY_BIT] = sample_ready_n;
        rd_word[31:`EIRS_STAT_CNT_LSB] = sample_cnt_r;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `EIRS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `EIRS_RESP_OKAY : `EIRS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arready) begin
        s_axi_arready <= !s_axi_arvalid;
      end else begin
        s_axi_arready <= !s_axi_rvalid;
      end
    end
  end

  for (genvar ch = 0; ch < `EIRS_CHAN_COUNT; ch++) begin : g_chan
    eirs_route_dec u_dec (
      .supply_en(supply_monitor_enable_r[ch]),
      .ctl(channel_route_control_r[ch]),
      .route(dec_route[ch])
    );
  end

  // The pace channel has no test or supply path, only free pin choice.
  eirs_route_dec u_pace_dec (
    .supply_en(1'b0),
    .ctl({`EIRS_TEST_OFF, pace_route_control_r.neg_sel, pace_route_control_r.pos_sel}),
    .route(pace_dec)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_route <= '0;
      pace_route <= '0;
    end else begin
      chan_route <= dec_route;
      pace_route <= pace_dec;
    end
  end

  // Shutdown is held as written; pairing it with supply monitoring is the host's duty.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      amplifier_shutdown <= '0;
    end else begin
      amplifier_shutdown <= front_end_shutdown_control_r;
    end
  end

  // One oscillator-rate tick and one frame counter serve every channel, so they cannot drift.
  assign osc_tick = (osc_cnt_r == OSC_CYC - 9'h1);
  assign period_eff = (period_r < `EIRS_PERIOD_MIN) ? `EIRS_PERIOD_MIN : period_r;
  assign frame_start = osc_tick && (frame_cnt_r == period_eff - 16'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt_r <= '0;
    end else begin
      osc_cnt_r <= osc_tick ? 9'h0 : osc_cnt_r + 9'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_cnt_r <= '0;
      sample_cnt_r <= '0;
    end else if (osc_tick) begin
      frame_cnt_r <= (frame_cnt_r >= period_eff - 16'h1) ? 16'h0 : frame_cnt_r + 16'h1;
      if (frame_start) begin
        sample_cnt_r <= sample_cnt_r + 16'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt_r <= '0;
      sample_ready_n <= 1'b1;
    end else if (frame_start) begin
      low_cnt_r <= READY_CYC - 11'h1;
      sample_ready_n <= 1'b0;
    end else if (low_cnt_r != 11'h0) begin
      low_cnt_r <= low_cnt_r - 11'h1;
    end else begin
      sample_ready_n <= 1'b1;
    end
  end

  logic [11:0] low_len_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_len_r <= '0;
    end else begin
      low_len_r <= sample_ready_n ? 12'h0 : low_len_r + 12'h1;
    end
  end

  ready_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(sample_ready_n) |-> $past(low_len_r) == 12'(READY_CYC) - 12'h1)
    else $error("sample ready low time wrong");

  ready_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(sample_ready_n) |-> $past(frame_start) && sample_cnt_r == $past(sample_cnt_r) + 16'h1)
    else $error("sample ready not tied to frame");

  supply_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    supply_monitor_enable_r[0] |=> chan_route[0].mode == EIRS_MODE_SUPPLY
      && chan_route[0].pos_pin == '0 && chan_route[0].neg_pin == '0)
    else $error("supply mode not taken");

  supply_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
    chan_route[1].mode == EIRS_MODE_SUPPLY |-> chan_route[1].pos_from_supply
      && chan_route[1].neg_from_ref && $past(supply_monitor_enable_r[1]))
    else $error("supply path wrong");

  test_short_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !supply_monitor_enable_r[2] && channel_route_control_r[2].test_sel == `EIRS_TEST_SHORT
      |=> chan_route[2].mode == EIRS_MODE_SHORT && chan_route[2].pos_pin == '0)
    else $error("short test not applied");

  test_pos_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !supply_monitor_enable_r[0] && channel_route_control_r[0].test_sel == `EIRS_TEST_POS
      |=> chan_route[0].mode == EIRS_MODE_TEST_POS)
    else $error("positive test not applied");

  test_neg_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !supply_monitor_enable_r[1] && channel_route_control_r[1].test_sel == `EIRS_TEST_NEG
      |=> chan_route[1].mode == EIRS_MODE_TEST_NEG && chan_route[1].neg_pin == '0)
    else $error("negative test not applied");

  test_prio_a: assert property (@(posedge aclk) disable iff (!aresetn)
    chan_route[0].mode inside {EIRS_MODE_SHORT, EIRS_MODE_TEST_POS, EIRS_MODE_TEST_NEG}
      |-> chan_route[0].pos_pin == '0 && chan_route[0].neg_pin == '0)
    else $error("pins routed during test");

  pin_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !supply_monitor_enable_r[0] && channel_route_control_r[0] == 8'h11
      |=> chan_route[0].pos_pin == 6'h01 && chan_route[0].neg_pin == 6'h02)
    else $error("pin route wrong");

  pace_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pace_route_control_r.pos_sel == 3'h6 |=> pace_route.pos_pin == 6'h20)
    else $error("pace pin route wrong");

  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  rdata_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");

endmodule : eirs_top
